//--- core/crpm_top.v
// Purpose: Crossbar routing registers two and three, port mismatch detect
// Assumes: Register bus synchronous to sys_clk; pins may be asynchronous
// Notes: Pin drivers and priority decoder live outside this block
// How it works
// [RULE1] Weak pullup disable bit 7: clear enables pullups, set disables all
// [RULE2] Bit 6 is global crossbar enable
// [RULE3] Bit 5 routes timer 1 external input to a pin
// [RULE4] Bit 4 routes timer 0 external input to a pin
// [RULE5] Bit 3 routes counter array external count input
// [RULE6] Channel field 000 none, 001..101 route channels 0..4 cumulatively
// [RULE7] Software never writes channel field codes 110 or 111
// [RULE8] Routing three bits 7:2 read zero, writes ignored
// [RULE9] Routing three bit 0 routes second UART transmit and receive
// [RULE10] Mismatch when masked port 0 or port 1 differs from expected
// [RULE11] Clear select bit excludes pin, set bit compares it
// [RULE12] Port 0 expected bit: 0 expects low, 1 expects high
// [RULE13] Comparison uses raw pin levels regardless of crossbar routing
// [RULE14] Mismatch serves as interrupt source and wake-up source
// [RULE15] Crossbar disabled keeps all port output drivers off
// [RULE16] Pullup off on any pin driving low
// [RULE17] Port 1 expected bits behave like port 0
// [RULE18] Pins synchronised to sys_clk; mismatch re-evaluated each cycle
// [RULE19] Software writes 0 to reserved bit 1 of routing three
`timescale 1ns/1ps
`default_nettype none
`include "crpm_defines.vh"

module crpm_top (
	input wire sys_clk, // System clock
	input wire rstn, // Async reset, active low
	input wire [7:0] reg_addr, // Register address
	input wire [7:0] reg_wdata, // Write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	output reg [7:0] reg_rdata, // Read data, registered
	output wire reg_hit, // Address maps to this block
	input wire [7:0] port0_pin, // Port 0 pin levels
	input wire [7:0] port1_pin, // Port 1 pin levels
	input wire [7:0] port0_drive_low, // Port 0 drivers pulling low
	input wire [7:0] port1_drive_low, // Port 1 drivers pulling low
	input wire [7:0] port0_open_drain, // Port 0 digital open-drain pins
	input wire [7:0] port1_open_drain, // Port 1 digital open-drain pins
	input wire [7:0] port0_out_req, // Port 0 driver requests
	input wire [7:0] port1_out_req, // Port 1 driver requests
	output reg [7:0] port0_out_en, // Port 0 driver enables
	output reg [7:0] port1_out_en, // Port 1 driver enables
	output reg [7:0] port0_pullup_en, // Port 0 weak pullups on
	output reg [7:0] port1_pullup_en, // Port 1 weak pullups on
	output reg crossbar_enable, // Crossbar routes peripherals
	output reg timer1_input_route, // Timer 1 input on a pin
	output reg timer0_input_route, // Timer 0 input on a pin
	output reg counter_array_ext_input_route, // Count input on a pin
	output reg [4:0] counter_array_channel_route, // Channel pins 0..4
	output reg second_uart_route, // Second UART on pins
	output reg port_mismatch, // Mismatch level
	output reg mismatch_irq, // Interrupt source level
	output reg mismatch_wake // Wake-up source level
);

reg [7:0] p0_expected_reg;
reg [7:0] p1_expected_reg;
reg [7:0] p0_select_reg;
reg [7:0] p1_select_reg;
reg [7:0] route_two_reg;
reg [`CRPM_R3_MSB:0] route_three_reg;
reg [7:0] p0_meta_reg;
reg [7:0] p0_sync_reg;
reg [7:0] p1_meta_reg;
reg [7:0] p1_sync_reg;
reg [7:0] rdata_next;
reg hit_next;
reg [4:0] ch_next;
wire mismatch_next;
wire xbar_on;
wire pullup_off;
wire [2:0] ch_code;
integer i;

// Routing two fields used by several outputs
assign xbar_on = route_two_reg[`CRPM_R2_XBAR_EN];
assign pullup_off = route_two_reg[`CRPM_R2_WEAK_PULLUP_DIS];
assign ch_code = route_two_reg[`CRPM_R2_CH_MSB:`CRPM_R2_CH_LSB];

// Register writes
always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		p0_expected_reg <= `CRPM_RST_EXPECTED;
		p1_expected_reg <= `CRPM_RST_EXPECTED;
		p0_select_reg <= `CRPM_RST_SELECT;
		p1_select_reg <= `CRPM_RST_SELECT;
		route_two_reg <= `CRPM_RST_ROUTE_TWO;
		route_three_reg <= `CRPM_RST_ROUTE_THREE;
	end
	else if (reg_wr)
	begin
		case (reg_addr)
			`CRPM_ADDR_P0_EXPECTED: p0_expected_reg <= reg_wdata;
			`CRPM_ADDR_P1_EXPECTED: p1_expected_reg <= reg_wdata;
			`CRPM_ADDR_P0_SELECT: p0_select_reg <= reg_wdata;
			`CRPM_ADDR_P1_SELECT: p1_select_reg <= reg_wdata;
			`CRPM_ADDR_ROUTE_TWO: route_two_reg <= reg_wdata;
			// Upper bits dropped
			`CRPM_ADDR_ROUTE_THREE:
				route_three_reg <= reg_wdata[`CRPM_R3_MSB:0]; // see [RULE8]
			default: route_two_reg <= route_two_reg;
		endcase
	end
end

// Read mux, unmapped reads zero
always @*
begin
	rdata_next = `CRPM_RST_BYTE;
	hit_next = 1'b1;
	case (reg_addr)
		`CRPM_ADDR_P0_EXPECTED: rdata_next = p0_expected_reg;
		`CRPM_ADDR_P1_EXPECTED: rdata_next = p1_expected_reg;
		`CRPM_ADDR_P0_SELECT: rdata_next = p0_select_reg;
		`CRPM_ADDR_P1_SELECT: rdata_next = p1_select_reg;
		`CRPM_ADDR_ROUTE_TWO: rdata_next = route_two_reg;
		`CRPM_ADDR_ROUTE_THREE:
			rdata_next = {`CRPM_R3_PAD, route_three_reg}; // see [RULE8]
		default: hit_next = 1'b0;
	endcase
end

assign reg_hit = hit_next;

// Read data holds until the next read
always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
		reg_rdata <= `CRPM_RST_BYTE;
	else if (reg_rd)
		reg_rdata <= rdata_next;
end

// Cumulative channel decode; reserved codes route nothing
always @*
begin
	ch_next = `CRPM_CH_NONE_MASK;
	for (i = 0; i < `CRPM_CH_PINS; i = i + 1)
		if (ch_code > i[2:0] &&
			ch_code <= `CRPM_CH_MAX)
			ch_next[i] = 1'b1; // see [RULE6] [RULE7]
end

// Pin synchronisers
// Two flops per pin; only the second one feeds the compare
always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		p0_meta_reg <= `CRPM_RST_BYTE;
		p0_sync_reg <= `CRPM_RST_BYTE;
		p1_meta_reg <= `CRPM_RST_BYTE;
		p1_sync_reg <= `CRPM_RST_BYTE;
	end
	else
	begin
		p0_meta_reg <= port0_pin; // see [RULE13] [RULE18]
		p0_sync_reg <= p0_meta_reg;
		p1_meta_reg <= port1_pin;
		p1_sync_reg <= p1_meta_reg;
	end
end

// Masked compare of both ports
assign mismatch_next =
	((p0_sync_reg & p0_select_reg) != (p0_expected_reg & p0_select_reg)) ||
	((p1_sync_reg & p1_select_reg) != (p1_expected_reg & p1_select_reg));
	// see [RULE10] [RULE11] [RULE12] [RULE17]

// Registered routing, driver and mismatch outputs
always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		crossbar_enable <= 1'b0;
		timer1_input_route <= 1'b0;
		timer0_input_route <= 1'b0;
		counter_array_ext_input_route <= 1'b0;
		counter_array_channel_route <= `CRPM_CH_NONE_MASK;
		second_uart_route <= 1'b0;
		port0_out_en <= `CRPM_ALL_OFF;
		port1_out_en <= `CRPM_ALL_OFF;
		port0_pullup_en <= `CRPM_ALL_OFF;
		port1_pullup_en <= `CRPM_ALL_OFF;
		port_mismatch <= 1'b0;
		mismatch_irq <= 1'b0;
		mismatch_wake <= 1'b0;
	end
	else
	begin
		crossbar_enable <= route_two_reg[`CRPM_R2_XBAR_EN]; // see [RULE2]
		timer1_input_route <= route_two_reg[`CRPM_R2_T1_ROUTE]; // see [RULE3]
		timer0_input_route <= route_two_reg[`CRPM_R2_T0_ROUTE]; // see [RULE4]
		counter_array_ext_input_route <=
			route_two_reg[`CRPM_R2_ECI_ROUTE]; // see [RULE5]
		counter_array_channel_route <= ch_next; // see [RULE6]
		second_uart_route <=
			route_three_reg[`CRPM_R3_UART_ROUTE]; // see [RULE9]
		port0_out_en <= xbar_on ?
			port0_out_req : `CRPM_ALL_OFF; // see [RULE15]
		port1_out_en <= xbar_on ?
			port1_out_req : `CRPM_ALL_OFF; // see [RULE15]
		// Pullups only on open-drain pins not pulling low
		port0_pullup_en <= pullup_off ? `CRPM_ALL_OFF :
			(port0_open_drain & ~port0_drive_low); // see [RULE1] [RULE16]
		port1_pullup_en <= pullup_off ? `CRPM_ALL_OFF :
			(port1_open_drain & ~port1_drive_low); // see [RULE1] [RULE16]
		// Event level plus its interrupt and wake-up copies
		port_mismatch <= mismatch_next; // see [RULE18]
		mismatch_irq <= mismatch_next; // see [RULE14]
		mismatch_wake <= mismatch_next; // see [RULE14]
	end
end

endmodule // crpm_top

`default_nettype wire

//--- shared/crpm_defines.vh
// Purpose: Constants for the crossbar routing and port match block
// Assumes: Internal register bus with 8-bit addresses and 8-bit data
// Notes: Definitions only
`ifndef CRPM_DEFINES_VH
`define CRPM_DEFINES_VH

// Register addresses
`define CRPM_ADDR_P0_EXPECTED 8'h84
`define CRPM_ADDR_P0_SELECT 8'hae
`define CRPM_ADDR_P1_EXPECTED 8'hb6
`define CRPM_ADDR_P1_SELECT 8'hba
`define CRPM_ADDR_ROUTE_TWO 8'he2
`define CRPM_ADDR_ROUTE_THREE 8'he3

// Reset values
`define CRPM_RST_EXPECTED 8'hff
`define CRPM_RST_SELECT 8'h00
`define CRPM_RST_ROUTE_TWO 8'h00
`define CRPM_RST_ROUTE_THREE 2'h0
`define CRPM_RST_BYTE 8'h00

// Drivers or pullups all switched off
`define CRPM_ALL_OFF 8'h00

// Routing control two fields
`define CRPM_R2_WEAK_PULLUP_DIS 7
`define CRPM_R2_XBAR_EN 6
`define CRPM_R2_T1_ROUTE 5
`define CRPM_R2_T0_ROUTE 4
`define CRPM_R2_ECI_ROUTE 3
`define CRPM_R2_CH_MSB 2
`define CRPM_R2_CH_LSB 0

// Routing control three fields
`define CRPM_R3_UART_ROUTE 0
`define CRPM_R3_RESERVED 1
`define CRPM_R3_MSB 1
`define CRPM_R3_PAD 6'h00

// Counter array channel count encodings
`define CRPM_CH_NONE 3'h0
`define CRPM_CH_MAX 3'h5
`define CRPM_CH_PINS 5
`define CRPM_CH_NONE_MASK 5'h00

`endif

//--- verif/crpm_pin_model.sv
// Purpose: Port 0 and port 1 pin source
// Assumes: Levels move just after a rising edge
// Notes: Pins always driven, no pulls
`timescale 1ns/1ps
`default_nettype none
module crpm_pin_model (
	input wire logic sys_clk, // Clock
	input wire logic [15:0] pin_lv, // Wanted levels
	output logic [7:0] port0_pin, // Port 0 pins
	output logic [7:0] port1_pin // Port 1 pins
);
	initial {port1_pin, port0_pin} = 16'hffff;
	always @(posedge sys_clk)
		{port1_pin, port0_pin} <= #1 pin_lv;
endmodule // crpm_pin_model
`default_nettype wire

//--- verif/crpm_props.sv
// Purpose: Port-level checks for crpm_top
// Assumes: Bound into every crpm_top instance
// Notes: Register effects seen through bus ports
`timescale 1ns/1ps
`default_nettype none
module crpm_props (
	input wire logic sys_clk, // Clock
	input wire logic rstn, // Reset, low
	input wire logic [7:0] reg_addr, // Address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write
	input wire logic reg_rd, // Read
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic reg_hit, // Mapped
	input wire logic [7:0] port0_drive_low, // Low drive
	input wire logic [7:0] port0_out_req, // Drive request
	input wire logic [7:0] port0_out_en, // Drive enable
	input wire logic [7:0] port0_pullup_en, // Pullups
	input wire logic crossbar_enable, // Crossbar
	input wire logic [4:0] counter_array_channel_route, // Channels
	input wire logic second_uart_route, // UART route
	input wire logic port_mismatch, // Mismatch
	input wire logic mismatch_irq, // Interrupt
	input wire logic mismatch_wake // Wake
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	a_drv_gated: assert property (
		!crossbar_enable |-> port0_out_en == 8'h00)
		else $error("driver on with crossbar off");
	a_drv_follow: assert property (
		crossbar_enable |-> port0_out_en == $past(port0_out_req))
		else $error("driver enable differs from request");
	a_pullup_low: assert property (
		(port0_pullup_en & $past(port0_drive_low)) == 8'h00)
		else $error("pullup on driven low pin");
	a_chan_thermo: assert property (
		counter_array_channel_route inside
		{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f})
		else $error("bad channels");
	a_xbar_write: assert property (
		reg_wr && reg_addr == 8'he2 |->
		##2 crossbar_enable == $past(reg_wdata[6], 2))
		else $error("crossbar bit not applied");
	a_uart_write: assert property (
		reg_wr && reg_addr == 8'he3 |->
		##2 second_uart_route == $past(reg_wdata[0], 2))
		else $error("uart bit not applied");
	a_rd_pad: assert property (
		reg_rd && reg_addr == 8'he3 ##1 !reg_rd |->
		##1 reg_rdata[7:2] == 6'h00)
		else $error("pad bits not zero");
	a_rd_unmapped: assert property (
		reg_rd && !reg_hit ##1 !reg_rd |-> ##1 reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_event_tie: assert property (
		mismatch_irq == port_mismatch && mismatch_wake == port_mismatch)
		else $error("event copies differ");
	c_drive: cover property (crossbar_enable && port0_out_en != 8'h00);
	c_mismatch: cover property (port_mismatch);
	c_all_chan: cover property (counter_array_channel_route == 5'h1f);
	c_uart_on: cover property (second_uart_route);
endmodule // crpm_props
bind crpm_top crpm_props u_props (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.reg_hit(reg_hit),
	.port0_drive_low(port0_drive_low),
	.port0_out_req(port0_out_req),
	.port0_out_en(port0_out_en),
	.port0_pullup_en(port0_pullup_en),
	.crossbar_enable(crossbar_enable),
	.counter_array_channel_route(counter_array_channel_route),
	.second_uart_route(second_uart_route),
	.port_mismatch(port_mismatch),
	.mismatch_irq(mismatch_irq),
	.mismatch_wake(mismatch_wake)
);
`default_nettype wire

//--- verif/crpm_top_tb.sv
// Purpose: Self-checking bench for crpm_top
// Assumes: Inputs move 1 ns after rising edge
// Notes: Random routing and match patterns
`timescale 1ns/1ps
`default_nettype none
module crpm_top_tb;
	logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, reg_hit;
	logic [7:0] reg_addr = 0, reg_wdata = 0, port0_out_req = 0;
	logic [7:0] port1_out_req = 0, port0_drive_low = 0, port1_drive_low = 0;
	logic [7:0] port0_open_drain = 0, port1_open_drain = 0, reg_rdata, v;
	logic [7:0] port0_pin, port1_pin, port0_out_en, port1_out_en;
	logic [7:0] port0_pullup_en, port1_pullup_en;
	logic crossbar_enable, timer1_input_route, timer0_input_route;
	logic counter_array_ext_input_route, second_uart_route;
	logic port_mismatch, mismatch_irq, mismatch_wake;
	logic [4:0] counter_array_channel_route;
	logic [15:0] pin_lv = 16'hffff;
	logic [63:0] r;
	logic [7:0] ra [7] = '{8'h84, 8'hae, 8'hb6, 8'hba, 8'he2, 8'he3, 8'h85};
	logic [7:0] rv [7] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
	int n_fail = 0, n_tests = 0;
	crpm_top dut (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.reg_hit(reg_hit),
		.port0_pin(port0_pin),
		.port1_pin(port1_pin),
		.port0_drive_low(port0_drive_low),
		.port1_drive_low(port1_drive_low),
		.port0_open_drain(port0_open_drain),
		.port1_open_drain(port1_open_drain),
		.port0_out_req(port0_out_req),
		.port1_out_req(port1_out_req),
		.port0_out_en(port0_out_en),
		.port1_out_en(port1_out_en),
		.port0_pullup_en(port0_pullup_en),
		.port1_pullup_en(port1_pullup_en),
		.crossbar_enable(crossbar_enable),
		.timer1_input_route(timer1_input_route),
		.timer0_input_route(timer0_input_route),
		.counter_array_ext_input_route(counter_array_ext_input_route),
		.counter_array_channel_route(counter_array_channel_route),
		.second_uart_route(second_uart_route),
		.port_mismatch(port_mismatch),
		.mismatch_irq(mismatch_irq),
		.mismatch_wake(mismatch_wake)
	);
	crpm_pin_model pm (
		.sys_clk(sys_clk),
		.pin_lv(pin_lv),
		.port0_pin(port0_pin),
		.port1_pin(port1_pin)
	);
	always #5 sys_clk = ~sys_clk;
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		tick(1);
		reg_wr = 0;
		tick(1);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1;
		tick(1);
		chk("hit", reg_hit, hit_exp(a));
		reg_rd = 0;
		tick(1);
		chk("rdata", reg_rdata, exp);
	endtask
	function logic hit_exp(input logic [7:0] a);
		return a == 8'h84 || a == 8'hae || a == 8'hb6 || a == 8'hba ||
			a == 8'he2 || a == 8'he3;
	endfunction
	function logic mm(input logic [63:0] q);
		return ((q[39:32] & q[7:0]) != (q[15:8] & q[7:0])) ||
			((q[47:40] & q[23:16]) != (q[31:24] & q[23:16]));
	endfunction
	task summarize();
		$display("tests %0d errors %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_fail++;
		summarize();
	end
	initial
	begin
		void'($urandom(32'h8044));
		tick(5);
		rstn = 1;
		for (int i = 0; i < 7; i++)
			rd(ra[i], rv[i]);
		wr(8'he3, 8'hfd);
		rd(8'he3, 8'h01);
		chk("uart", second_uart_route, 1'b1);
		wr(8'he3, 8'h00);
		chk("uart", second_uart_route, 1'b0);
		for (int c = 0; c < 6; c++)
		begin
			v = {c[1], c[0], 3'($urandom), c[2:0]};
			{port1_out_req, port0_out_req} = 16'($urandom);
			{port1_open_drain, port0_open_drain} = 16'($urandom);
			{port1_drive_low, port0_drive_low} = 16'($urandom);
			wr(8'he2, v);
			chk("chan", counter_array_channel_route,
				5'h1f >> (5 - c));
			chk("route", {crossbar_enable, timer1_input_route,
				timer0_input_route, counter_array_ext_input_route},
				v[6:3]);
			chk("oe", {port1_out_en, port0_out_en}, {port1_out_req,
				port0_out_req} & {16{v[6]}});
			chk("pu", {port1_pullup_en, port0_pullup_en}, v[7] ? 16'h0 :
				{port1_open_drain, port0_open_drain} &
				~{port1_drive_low, port0_drive_low});
			rd(8'he2, v);
		end
		rstn = 0;
		tick(2);
		chk("rst", {port_mismatch, crossbar_enable, second_uart_route,
			counter_array_channel_route, port0_out_en}, 16'h0);
		rstn = 1;
		for (int i = 0; i < 7; i++)
			rd(ra[i], rv[i]);
		for (int i = 0; i < 24; i++)
		begin
			r = {$urandom, $urandom};
			if (i < 2)
				r[23:0] = r[23:0] & 24'h00ff00;
			if (!i[0])
				r[47:32] = {r[31:24], r[15:8]} ^ (16'h1 << i[4:1]);
			wr(8'hae, r[7:0]);
			wr(8'h84, r[15:8]);
			wr(8'hba, r[23:16]);
			wr(8'hb6, r[31:24]);
			wr(8'he2, {5'($urandom), 3'h1});
			pin_lv = r[47:32];
			tick(5);
			chk("match", port_mismatch, mm(r));
			chk("irq", mismatch_irq, mm(r));
			chk("wake", mismatch_wake, mm(r));
		end
		summarize();
	end
endmodule // crpm_top_tb
`default_nettype wire
